// *** adc_buf_if.sv ***
// Link between the sequencer and its result buffer store.
// Assumes both ends run on the same clock as the sequencer.
`timescale 1ns/1ps
`default_nettype none
interface adc_buf_if;
   import adc_seq_pkg::*;
   logic wr;                              // One-cycle pulse: store a result.
   logic [RES_W-1:0] wdata;               // Result to store.
   logic wrap;                            // With wr: pointer returns to buffer zero.
   logic dma;                             // DMA mode: only buffer zero is used.
   logic [BUF_IDX_W-1:0] rd_idx;          // Buffer being read.
   logic [RES_W-1:0] rd_data;             // Contents of that buffer.
   logic [BUF_IDX_W-1:0] ptr;             // Next buffer to be written.
   modport seq (output wr, wdata, wrap, dma, rd_idx, input rd_data, ptr);
   modport store (input wr, wdata, wrap, dma, rd_idx, output rd_data, ptr);
endinterface : adc_buf_if
`default_nettype wire

// *** adc_dma_reader.sv ***
// Model of the DMA reader that follows the request and step pulses.
// Assumes one-cycle pulses on the sequencer clock.
`timescale 1ns/1ps
`default_nettype none
module adc_dma_reader (
   input wire logic clk_i,      // System clock.
   input wire logic rst_i,      // Asynchronous reset, active high.
   input wire logic req_i,      // Result ready in the first buffer.
   input wire logic step_i,     // Advance the destination address.
   output logic [15:0] reads_o, // Results fetched so far.
   output logic [15:0] addr_o   // Destination word address.
);
   // Fetches each result in the cycle it is offered, before the next lands.
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         reads_o <= 16'h0000;
         addr_o <= 16'h0000;
      end else begin
         if (req_i) begin
            reads_o <= reads_o + 16'h0001;
         end
         if (step_i) begin
            addr_o <= addr_o + 16'h0001;
         end
      end
   end
endmodule : adc_dma_reader
`default_nettype wire

// *** adc_result_buffer_sequencer.sv ***
// Converter sequencing: completion counting, flag, scan list, buffer and DMA stepping.
// Assumes the analog core pulses conv_begin_i and conv_done_i on this clock.
//
// What this block does
// - Raise flag when count reaches samples-per-interrupt.
// - Scan list restarts at that same count.
// - Without DMA, buffer pointer wraps at count.
// - DMA mode uses only the first buffer.
// - DMA address advances every 32nd conversion.
// - Sixteen buffers filled in order, channel ignored.
// - DMA buffer overwritten; reader must keep up.
// - Done clears at start, sets at completion.
//
// The placing of the registers and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module adc_result_buffer_sequencer (
   input wire logic clk_i,                                  // System clock, 10 MHz.
   input wire logic rst_i,                                  // Asynchronous reset, high.
   input wire logic [adc_seq_pkg::ADDR_W-1:0] addr_i,       // Register word address.
   input wire logic [adc_seq_pkg::DATA_W-1:0] wdata_i,      // Register write data.
   input wire logic wr_i,                                   // Write strobe.
   input wire logic rd_i,                                   // Read strobe.
   output logic [adc_seq_pkg::DATA_W-1:0] rdata_o,          // Read data, next cycle.
   input wire logic conv_begin_i,                           // Conversion start pulse.
   input wire logic conv_done_i,                            // Conversion end pulse.
   input wire logic [adc_seq_pkg::RES_W-1:0] result_i,      // Result with conv_done_i.
   output logic sample_o,                                   // Sample request level.
   output logic [adc_seq_pkg::CHAN_W-1:0] chan_o,           // Channel to sample.
   output logic done_o,                                     // Conversion done status.
   output logic flag_o,                                     // Conversion complete flag.
   output logic scan_restart_o,                             // Scan list restart pulse.
   output logic dma_req_o,                                  // Result ready for DMA.
   output logic dma_addr_inc_o                              // DMA address step pulse.
);
   import adc_seq_pkg::*;

   // All state of the sequencer in one record.
   typedef struct packed {
      logic done;                      // Conversion done status.
      logic sample_start_bit;                      // Sample start bit.
      logic flag;                      // Conversion complete flag.
      logic scan_en;                   // Channel scan enable.
      logic dma_en;                    // DMA mode enable.
      logic [SMPI_W-1:0] smpi;         // Samples per interrupt, minus one.
      logic [CHAN_W-1:0] chan_fix;     // Channel used without scanning.
      logic [15:0] sel_lo;             // Scan mask, low half.
      logic [15:0] sel_hi;             // Scan mask, high half.
      logic [SMPI_W-1:0] cnt;          // Completed conversions in this group.
      logic [4:0] dma_cnt;             // Conversions since the last DMA step.
      logic [CHAN_W-1:0] chan;         // Current scan channel.
      logic scan_rst;                  // Scan restart pulse.
      logic dma_req;                   // DMA request pulse.
      logic dma_inc;                   // DMA address step pulse.
      logic [DATA_W-1:0] rdata;        // Read data register.
   } seq_t;

   seq_t st;                           // Registered state.
   seq_t next_st;                      // Next state.
   adc_buf_if bif ();                  // Link to the result store.

   // Finds the next selected channel after cur, wrapping; keeps cur if none selected.
   function automatic logic [CHAN_W-1:0] next_sel(input logic [31:0] m,
                                                  input logic [CHAN_W-1:0] cur);
      logic [CHAN_W-1:0] r;
      logic [CHAN_W-1:0] idx;
      logic found;
      r = cur;
      idx = cur;
      found = 1'b0;
      for (int i = 1; i <= 32; i++) begin
         idx = cur + 5'(i);
         if (!found && m[idx]) begin
            r = idx;
            found = 1'b1;
         end
      end
      return r;
   endfunction : next_sel

   // Buffer store instance.
   adc_result_store u_store (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .bus(bif.store)
   );

   // Requests toward the store follow the conversion events directly.
   logic group_end;                                   // Last conversion of the group.
   assign group_end = conv_done_i && (st.cnt == st.smpi);
   assign bif.wr = conv_done_i;
   assign bif.wdata = result_i;
   assign bif.wrap = group_end;
   assign bif.dma = st.dma_en;
   assign bif.rd_idx = addr_i[BUF_IDX_W-1:0];

   // Next-state logic: register writes, conversion events, reads.
   always_comb begin
      next_st = st;
      next_st.scan_rst = 1'b0;
      next_st.dma_req = 1'b0;
      next_st.dma_inc = 1'b0;
      // Register writes; flags only clear by writing zero.
      if (wr_i) begin
         unique case (addr_i)
            ADC_CONTROL_ONE: begin
               if (!wdata_i[DONE_BIT]) begin
                  next_st.done = 1'b0;
               end
               if (!wdata_i[FLAG_BIT]) begin
                  next_st.flag = 1'b0;
               end
               next_st.sample_start_bit = wdata_i[SAMPLE_START_BIT];
            end
            ADC_CONTROL_TWO: begin
               next_st.smpi = wdata_i[SMPI_LSB +: SMPI_W];
               next_st.scan_en = wdata_i[SCAN_EN_BIT];
               next_st.dma_en = wdata_i[DMA_EN_BIT];
               next_st.chan_fix = wdata_i[CHAN_LSB +: CHAN_W];
            end
            SCAN_SELECT_LOW: begin
               next_st.sel_lo = wdata_i;
            end
            SCAN_SELECT_HIGH: begin
               next_st.sel_hi = wdata_i;
            end
            default: begin
               // Status and buffers are read-only; other addresses ignore writes.
            end
         endcase
      end
      // A conversion start ends sampling and clears done.
      if (conv_begin_i) begin
         next_st.done = 1'b0;
         next_st.sample_start_bit = 1'b0;
      end
      // Completion sets done and steps the counters; sets win over clears.
      if (conv_done_i) begin
         next_st.done = 1'b1;
         next_st.dma_req = st.dma_en;
         if (group_end) begin
            next_st.cnt = '0;
            next_st.flag = 1'b1;
            if (st.scan_en) begin
               next_st.chan = next_sel({st.sel_hi, st.sel_lo}, 5'h1f);
               next_st.scan_rst = 1'b1;
            end
         end else begin
            next_st.cnt = st.cnt + 5'h01;
            if (st.scan_en) begin
               next_st.chan = next_sel({st.sel_hi, st.sel_lo}, st.chan);
            end
         end
         if (st.dma_en) begin
            if (st.dma_cnt == DMA_LAST) begin
               next_st.dma_cnt = '0;
               next_st.dma_inc = 1'b1;
            end else begin
               next_st.dma_cnt = st.dma_cnt + 5'h01;
            end
         end
      end
      if (!st.dma_en) begin
         next_st.dma_cnt = '0;
      end
      // Read data stands in the cycle after the strobe only.
      next_st.rdata = '0;
      if (rd_i) begin
         if (addr_i >= RESULT_BASE) begin
            next_st.rdata = DATA_W'(bif.rd_data);
         end else begin
            unique case (addr_i)
               ADC_CONTROL_ONE: begin
                  next_st.rdata[DONE_BIT] = st.done;
                  next_st.rdata[SAMPLE_START_BIT] = st.sample_start_bit;
                  next_st.rdata[FLAG_BIT] = st.flag;
               end
               ADC_CONTROL_TWO: begin
                  next_st.rdata[SMPI_LSB +: SMPI_W] = st.smpi;
                  next_st.rdata[SCAN_EN_BIT] = st.scan_en;
                  next_st.rdata[DMA_EN_BIT] = st.dma_en;
                  next_st.rdata[CHAN_LSB +: CHAN_W] = st.chan_fix;
               end
               SCAN_SELECT_LOW: begin
                  next_st.rdata = st.sel_lo;
               end
               SCAN_SELECT_HIGH: begin
                  next_st.rdata = st.sel_hi;
               end
               SEQ_STATUS: begin
                  next_st.rdata[STAT_PTR_LSB +: BUF_IDX_W] = bif.ptr;
                  next_st.rdata[STAT_CNT_LSB +: SMPI_W] = st.cnt;
                  next_st.rdata[STAT_CHAN_LSB +: CHAN_W] = chan_o;
               end
               default: begin
                  next_st.rdata = '0;                      // Unmapped reads as zero.
               end
            endcase
         end
      end
   end

   // Registers the whole state.
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         st <= '{smpi: SMPI_RST, sel_lo: SEL_RST, sel_hi: SEL_RST, default: '0};
      end else begin
         st <= next_st;
      end
   end

   // Outputs straight from the state.
   assign rdata_o = st.rdata;
   assign sample_o = st.sample_start_bit;
   assign chan_o = st.scan_en ? st.chan : st.chan_fix;
   assign done_o = st.done;
   assign flag_o = st.flag;
   assign scan_restart_o = st.scan_rst;
   assign dma_req_o = st.dma_req;
   assign dma_addr_inc_o = st.dma_inc;
endmodule : adc_result_buffer_sequencer
`default_nettype wire

// *** adc_result_buffer_sequencer_tb.sv ***
// Self-checking bench for the converter sequencer.
// Assumes the register map and timing of the shared package.
`timescale 1ns/1ps
`default_nettype none
module adc_result_buffer_sequencer_tb;
   import adc_seq_pkg::*;
   logic clk_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
   logic conv_begin_i = 1'b0, conv_done_i = 1'b0;
   logic [ADDR_W-1:0] addr_i = '0;
   logic [DATA_W-1:0] wdata_i = '0, rdata_o;
   logic [RES_W-1:0] result_i = '0;
   logic sample_o, done_o, flag_o, scan_restart_o, dma_req_o, dma_addr_inc_o;
   logic [CHAN_W-1:0] chan_o;
   logic [15:0] reads, dma_addr;
   int err_total = 0;
   int samples_checked = 0;
   always #50 clk_i = ~clk_i;
   adc_result_buffer_sequencer dut_u (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .conv_begin_i(conv_begin_i), .conv_done_i(conv_done_i), .result_i(result_i),
      .sample_o(sample_o), .chan_o(chan_o), .done_o(done_o), .flag_o(flag_o),
      .scan_restart_o(scan_restart_o), .dma_req_o(dma_req_o), .dma_addr_inc_o(dma_addr_inc_o));
   adc_dma_reader dma_u (.clk_i(clk_i), .rst_i(rst_i), .req_i(dma_req_o),
      .step_i(dma_addr_inc_o), .reads_o(reads), .addr_o(dma_addr));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask : wr
   task automatic rd(input logic [ADDR_W-1:0] a, input logic [15:0] exp);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1;
      chk(rdata_o, exp);
   endtask : rd
   task automatic conv(input logic [RES_W-1:0] r);
      @(posedge clk_i);
      result_i <= r;
      conv_done_i <= 1'b1;
      @(posedge clk_i);
      conv_done_i <= 1'b0;
      #1;
   endtask : conv
   task automatic t_scan;
      rd(ADC_CONTROL_TWO, 16'h0000);
      rd(SCAN_SELECT_LOW, 16'h0000);
      wr(SCAN_SELECT_LOW, 16'h0006);
      wr(ADC_CONTROL_TWO, 16'h0021);
      for (int i = 0; i < 4; i++) begin
         conv(12'(i));
         chk({11'h0, scan_restart_o, flag_o, 3'(chan_o)}, (i % 2) ? 16'h0019 : ((i == 0) ? 16'h0001 : 16'h000a));
      end
      $display("scan test done");
   endtask : t_scan
   task automatic t_buffers;
      wr(ADC_CONTROL_ONE, 16'h0000);
      wr(ADC_CONTROL_TWO, 16'h000f);
      for (int i = 0; i < 16; i++) begin
         conv(12'(i + 'h100));
         if (i == 4) rd(SEQ_STATUS, 16'h0055);
         chk({15'h0, flag_o}, {15'h0, i == 15});
      end
      wr(SEQ_STATUS, 16'hffff);
      rd(SEQ_STATUS, 16'h0000);
      rd(5'h08, 16'h0000);
      for (int i = 0; i < 16; i++) rd(RESULT_BASE + 5'(i), 16'(i + 'h100));
      $display("buffer test done");
   endtask : t_buffers
   task automatic t_done;
      wr(ADC_CONTROL_ONE, 16'h0002);
      @(negedge clk_i);
      chk({13'h0, flag_o, done_o, sample_o}, 16'h0001);
      @(posedge clk_i);
      conv_begin_i <= 1'b1;
      @(posedge clk_i);
      conv_begin_i <= 1'b0;
      #1;
      chk({14'h0, done_o, sample_o}, 16'h0000);
      conv(12'h0aa);
      repeat (5) @(posedge clk_i);
      @(negedge clk_i);
      chk({15'h0, done_o}, 16'h0001);
      // The next conversion start must drop the done status that is still standing.
      @(posedge clk_i);
      conv_begin_i <= 1'b1;
      @(posedge clk_i);
      conv_begin_i <= 1'b0;
      #1;
      chk({15'h0, done_o}, 16'h0000);
      $display("done test done");
   endtask : t_done
   task automatic t_dma;
      wr(ADC_CONTROL_TWO, 16'h0047);
      for (int i = 0; i < 64; i++) conv(12'(i));
      // The reader takes the last request and step pulse one edge later.
      @(posedge clk_i);
      #1;
      chk(reads, 16'd64);
      chk(dma_addr, 16'd2);
      chk({15'h0, flag_o}, 16'h0001);
      rd(RESULT_BASE, 16'h003f);
      rd(RESULT_BASE + 5'h01, 16'h0101);
      $display("dma test done");
   endtask : t_dma
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : report_and_stop
   // Runs the scenarios in an order that keeps the group counters aligned.
   initial begin
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      t_scan;
      t_buffers;
      t_done;
      t_dma;
      report_and_stop;
   end
   // Cuts a hang short, well past the few hundred cycles the run needs.
   initial begin
      #500000;
      err_total++;
      report_and_stop;
   end
endmodule : adc_result_buffer_sequencer_tb
bind adc_result_buffer_sequencer adc_seq_assertions chk_u (.clk_i(clk_i), .rst_i(rst_i),
   .wr_i(wr_i), .conv_begin_i(conv_begin_i), .conv_done_i(conv_done_i), .done_o(done_o),
   .flag_o(flag_o), .scan_restart_o(scan_restart_o), .dma_req_o(dma_req_o),
   .dma_addr_inc_o(dma_addr_inc_o));
`default_nettype wire

// *** adc_result_store.sv ***
// Sixteen-entry result buffer store with its fill pointer.
// Assumes write requests come from the sequencer on the same clock.
`timescale 1ns/1ps
`default_nettype none
module adc_result_store (
   input wire logic clk_i,          // System clock.
   input wire logic rst_i,          // Asynchronous reset, active high.
   adc_buf_if.store bus             // Link from the sequencer.
);
   import adc_seq_pkg::*;

   // The whole state of the store besides the memory is the pointer.
   typedef struct packed {
      logic [BUF_IDX_W-1:0] ptr;    // Next buffer to fill.
   } store_t;

   store_t st;                      // Registered state.
   store_t next_st;                 // Next state.
   logic [RES_W-1:0] mem [NUM_BUFS]; // Result buffers.

   // Pointer steps through the buffers; wraps on request; held at zero under DMA.
   always_comb begin
      next_st = st;
      if (bus.dma) begin
         next_st.ptr = '0;
      end else if (bus.wr) begin
         if (bus.wrap) begin
            next_st.ptr = '0;
         end else begin
            next_st.ptr = st.ptr + 4'h1;
         end
      end
   end

   // Registers the pointer.
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // Stores a result in sequence regardless of channel; DMA mode overwrites buffer zero.
   always_ff @(posedge clk_i) begin
      if (bus.wr) begin
         mem[bus.dma ? 4'h0 : st.ptr] <= bus.wdata;
      end
   end

   assign bus.rd_data = mem[bus.rd_idx];  // Read port for the register file.
   assign bus.ptr = st.ptr;               // Pointer shown in the status register.
endmodule : adc_result_store
`default_nettype wire

// *** adc_seq_assertions.sv ***
// Port-level checks of the converter sequencer.
// Assumes it is bound to the sequencer top module on one clock.
`timescale 1ns/1ps
`default_nettype none
module adc_seq_assertions (
   input wire logic clk_i,          // System clock.
   input wire logic rst_i,          // Asynchronous reset, active high.
   input wire logic wr_i,           // Register write strobe.
   input wire logic conv_begin_i,   // Conversion start pulse.
   input wire logic conv_done_i,    // Conversion end pulse.
   input wire logic done_o,         // Conversion done status.
   input wire logic flag_o,         // Conversion complete flag.
   input wire logic scan_restart_o, // Scan list restart pulse.
   input wire logic dma_req_o,      // Result ready for DMA.
   input wire logic dma_addr_inc_o  // DMA address step pulse.
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   logic [5:0] req_gap; // Requests since the last step, saturating.
   // Counts DMA requests so that each step can be tied to a full stride.
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         req_gap <= 6'h00;
      end else if (dma_addr_inc_o) begin
         req_gap <= 6'h00;
      end else if (dma_req_o && req_gap != 6'h3f) begin
         req_gap <= req_gap + 6'h01;
      end
   end
   done_set_a:
      assert property (conv_done_i |=> done_o) else $error("done not set after completion");
   done_clear_a:
      assert property (conv_begin_i && !conv_done_i |=> !done_o) else $error("done not cleared");
   done_hold_a:
      assert property (done_o && !conv_begin_i && !wr_i |=> done_o) else $error("done dropped");
   flag_rise_a:
      assert property ($rose(flag_o) |-> $past(conv_done_i)) else $error("flag without completion");
   flag_hold_a:
      assert property (flag_o && !wr_i |=> flag_o) else $error("flag dropped by itself");
   scan_restart_a:
      assert property (scan_restart_o |-> $past(conv_done_i) && flag_o) else $error("bad restart");
   dma_req_a:
      assert property (dma_req_o |-> $past(conv_done_i)) else $error("request without result");
   dma_step_a:
      assert property (dma_addr_inc_o |-> dma_req_o && req_gap >= 6'h1f) else $error("early step");
endmodule : adc_seq_assertions
`default_nettype wire

// *** adc_seq_pkg.sv ***
// Shared constants of the converter result sequencer: register map, fields, reset values.
// Assumes a 16-bit register port with word addresses and a single system clock.
package adc_seq_pkg;
   localparam int ADDR_W = 5;                       // Register port address width.
   localparam int DATA_W = 16;                      // Register port data width.
   localparam int RES_W = 12;                       // Width of one conversion result.
   localparam int NUM_BUFS = 16;                    // Result buffers without DMA.
   localparam int BUF_IDX_W = 4;                    // Width of a buffer pointer.
   localparam int DMA_STRIDE = 32;                  // Conversions per DMA address step.
   localparam logic [4:0] DMA_LAST = 5'(DMA_STRIDE - 1); // Last count before a DMA step.
   // Register offsets, word addresses.
   localparam logic [ADDR_W-1:0] ADC_CONTROL_ONE = 5'h00;   // Done, sample start, flag.
   localparam logic [ADDR_W-1:0] ADC_CONTROL_TWO = 5'h01;   // Count, scan, DMA, channel.
   localparam logic [ADDR_W-1:0] SCAN_SELECT_LOW = 5'h02;   // Scan mask, channels 0-15.
   localparam logic [ADDR_W-1:0] SCAN_SELECT_HIGH = 5'h03;  // Scan mask, channels 16-31.
   localparam logic [ADDR_W-1:0] SEQ_STATUS = 5'h04;        // Pointer, count, channel.
   localparam logic [ADDR_W-1:0] RESULT_BASE = 5'h10;       // First result buffer.
   // Field positions of control one.
   localparam int DONE_BIT = 0;                     // Conversion done status.
   localparam int SAMPLE_START_BIT = 1;             // Software sample start.
   localparam int FLAG_BIT = 2;                     // Conversion complete flag.
   // Field positions of control two.
   localparam int SMPI_LSB = 0;                     // Samples per interrupt, minus one.
   localparam int SMPI_W = 5;                       // Width of that field.
   localparam int SCAN_EN_BIT = 5;                  // Channel scan enable.
   localparam int DMA_EN_BIT = 6;                   // DMA mode enable.
   localparam int CHAN_LSB = 7;                     // Fixed channel, primary selector.
   localparam int CHAN_W = 5;                       // Width of a channel number.
   // Field positions of the status register.
   localparam int STAT_PTR_LSB = 0;                 // Buffer pointer.
   localparam int STAT_CNT_LSB = 4;                 // Completed conversion count.
   localparam int STAT_CHAN_LSB = 9;                // Current channel.
   // Reset values.
   localparam logic [SMPI_W-1:0] SMPI_RST = 5'h00;  // Flag after every conversion.
   localparam logic [15:0] SEL_RST = 16'h0000;      // Nothing selected for scan.
endpackage : adc_seq_pkg
